/* its_cond_det.sv */
`timescale 1ns/1ps
module its_cond_det (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic scl_lvl,
    input  wire logic sda_lvl,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det
);
    import its_pkg::*;

    logic scl_prev_q;
    logic sda_prev_q;

    // ==========================================================
    // edge memory, lines idle high
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_lvl;
            sda_prev_q <= sda_lvl;
        end
    end

    // data moving while the clock is high marks a frame boundary
    assign scl_rise  = scl_lvl & ~scl_prev_q;
    assign scl_fall  = ~scl_lvl & scl_prev_q;
    assign start_det = scl_lvl & scl_prev_q & sda_prev_q & ~sda_lvl;
    assign stop_det  = scl_lvl & scl_prev_q & ~sda_prev_q & sda_lvl;

endmodule : its_cond_det

/* its_master_model.sv */
`timescale 1ns/1ps
module its_master_model (
    input wire logic scl_lvl,
    input wire logic sda_lvl,
    output logic     scl_drv,
    output logic     sda_drv
);
    // ==========================================
    // released lines float high; clock stands still between frames
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // data changes only in the low phase; a stretched clock is waited out, bounded
    task automatic bit_io(input logic b, output logic r);
        int n;
        #21.3 sda_drv = b;
        #58.7 scl_drv = 1'b1;
        n = 0;
        // let the wired line settle so an unstretched bit stays 125 ns
        #0;
        while (!scl_lvl && n < 20000) begin
            #5;
            n++;
        end
        #45 r = sda_lvl;
        scl_drv = 1'b0;
    endtask : bit_io
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] got,
                        output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], got[i]);
        bit_io(a, ack);
    endtask : xfer
    task automatic start_cond();
        #62.5 sda_drv = 1'b0;
        #62.5 scl_drv = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        #21.3 sda_drv = 1'b0;
        #40 scl_drv = 1'b1;
        #62.5 sda_drv = 1'b1;
        #62.5;
    endtask : stop_cond
endmodule : its_master_model

/* its_monitor.sv */
`timescale 1ns/1ps
module its_monitor
    import its_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       scl_o,
    input wire logic       scl_oe,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic       irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // shadow copies; mask starts all ones so nothing is judged before software writes it
    logic [7:0] cfg_q;
    logic [7:0] msk_q;
    logic       hold;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) cfg_q <= CFG_RESET;
        else if (reg_wr && reg_addr == ADR_CFG) cfg_q <= reg_wdata & CFG_MASK;
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) msk_q <= 8'hff;
        else if (reg_wr && reg_addr == ADR_IRQ_MASK) msk_q <= reg_wdata;
    end
    assign hold = cfg_q[CFG_EN] & ~cfg_q[CFG_CLK_REL] & ~cfg_q[CFG_SOFT_RST];
    // ==========================================
    // checks
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_pins_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("open drain output drives high");
    a_flags_excl: assert property ($past(reg_rd) && $past(reg_addr) == ADR_STAT
        |-> reg_rdata[ST_START] != reg_rdata[ST_STOP]) else $error("start and stop flags agree");
    a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00
        |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_cfg_readback: assert property ($past(reg_rd) && $past(reg_addr) == ADR_CFG
        |-> reg_rdata == $past(cfg_q)) else $error("config readback wrong");
    a_idle_quiet: assert property (!cfg_q[CFG_EN] && !$past(cfg_q[CFG_EN])
        |-> !scl_oe && !sda_oe) else $error("disabled target drives the bus");
    a_clk_hold: assert property (hold && $past(hold) |-> scl_oe)
        else $error("clock line not held low");
    a_irq_masked: assert property (msk_q == 8'h00 && $past(msk_q) == 8'h00 |-> !irq)
        else $error("interrupt while fully masked");
    c_ack: cover property ($rose(sda_oe));
    c_stretch: cover property (scl_oe && cfg_q[CFG_CLK_REL]);
    c_irq: cover property ($rose(irq));
endmodule : its_monitor

bind its_target its_monitor u_its_monitor (
    .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .scl_o, .scl_oe, .sda_o, .sda_oe, .irq
);

/* its_pkg.sv */
package its_pkg;

    // ==========================================================
    // bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ==========================================================
    // register offsets
    localparam logic [ADDR_W-1:0] ADR_OWN      = 8'he3;
    localparam logic [ADDR_W-1:0] ADR_CFG      = 8'he5;
    localparam logic [ADDR_W-1:0] ADR_STAT     = 8'he8;
    localparam logic [ADDR_W-1:0] ADR_BUF      = 8'he9;
    localparam logic [ADDR_W-1:0] ADR_IRQ_STAT = 8'hea;
    localparam logic [ADDR_W-1:0] ADR_IRQ_MASK = 8'heb;

    // ==========================================================
    // status bit positions
    localparam int ST_START = 7;
    localparam int ST_STOP  = 6;
    localparam int ST_DIR   = 5;
    localparam int ST_DATA  = 4;
    localparam int ST_FULL  = 3;
    localparam int ST_NACK  = 2;
    localparam int ST_WCOL  = 1;
    localparam int ST_OVR   = 0;

    // ==========================================================
    // configuration bit positions and reset values
    localparam int CFG_EN        = 0;
    localparam int CFG_CLK_REL   = 2;
    localparam int CFG_RD_STRTCH = 4;
    localparam int CFG_SOFT_RST  = 5;
    localparam logic [DATA_W-1:0] CFG_MASK  = 8'h3f;
    localparam logic [DATA_W-1:0] CFG_RESET = 8'h10;
    localparam logic [DATA_W-1:0] OWN_RESET = 8'h00;
    localparam logic [DATA_W-1:0] BUF_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    // ==========================================================
    // interrupt event positions
    localparam int IRQ_W     = 5;
    localparam int IRQ_START = 0;
    localparam int IRQ_STOP  = 1;
    localparam int IRQ_RX    = 2;
    localparam int IRQ_TX    = 3;
    localparam int IRQ_ERR   = 4;
    localparam logic [IRQ_W-1:0] IRQ_NONE = 5'h00;

    // ==========================================================
    // bit counting
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;
    localparam logic [CNT_W-1:0] CNT_BYTE  = 4'h8;
    localparam logic [CNT_W-1:0] CNT_TXEND = 4'h7;
    localparam logic [2:0]       TX_MSB    = 3'h7;

    // ==========================================================
    // target sequencer, gray along address -> ack -> data -> ack
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_ADDR   = 3'h1,
        ST_A_ACK  = 3'h3,
        ST_RX     = 3'h2,
        ST_RX_ACK = 3'h6,
        ST_TX     = 3'h7,
        ST_TX_ACK = 3'h5
    } its_state_e;

endpackage : its_pkg

/* its_sync.sv */
`timescale 1ns/1ps
module its_sync #(
    parameter int          WIDTH     = 2,
    parameter logic [31:0] RESET_VAL = 32'hffffffff
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_out
);
    import its_pkg::*;

    // ==========================================================
    // three stages; a level is taken once stage two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    s1_q         <= RESET_VAL[g];
                    s2_q         <= RESET_VAL[g];
                    s3_q         <= RESET_VAL[g];
                    level_out[g] <= RESET_VAL[g];
                end else begin
                    s1_q <= async_in[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        level_out[g] <= s3_q;
                    end
                end
            end
        end
    endgenerate

endmodule : its_sync

/* its_target.sv */
// Functional notes
// - status bit 7 goes high on a detected start and stays 1 until a stop, 0 at reset.
// - status bit 6 is high while the bus is stopped, low after a start, 1 at reset.
// - on an address match the direction bit of the address byte lands in status bit 5.
// - status bit 4 is 1 after a data byte and 0 after an address byte.
// - receiving, status bit 3 rises when a whole byte sits in the buffer.
// - sending, status bit 3 stays 1 while the byte shifts out and drops when sent.
// - status bit 2 is 1 on a missing acknowledge, 0 on a valid one, 1 at reset.
// - a buffer write during a send is dropped and raises status bit 1.
// - a byte arriving over an unread one is dropped and raises status bit 0.
// - the status register sits at e8, bits 7..2 read only, bits 1..0 writable.
// - the data buffer sits at e9, resets to zero, write loads send data, read gives rx.
// - the target joins bus traffic only while configuration bit 0 is 1.
// - the received address is checked against own address bits 7..1.
// - configuration bit 2 at 0 holds the clock line low while enabled and not in soft reset; at 1 it is released.
// - configuration bit 4 at 1 stretches the clock on reads until data is loaded.
`timescale 1ns/1ps
module its_target (
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    input  wire logic [its_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [its_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [its_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                        scl_i,
    output logic                             scl_o,
    output logic                             scl_oe,
    input  wire logic                        sda_i,
    output logic                             sda_o,
    output logic                             sda_oe,
    output logic                             irq
);
    import its_pkg::*;

    // ==========================================================
    // pin conditioning
    logic [1:0] pins_lvl;
    logic       scl_lvl;
    logic       sda_lvl;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    its_sync #(
        .WIDTH     (2),
        .RESET_VAL (32'hffffffff)
    ) u_sync (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .async_in  ({sda_i, scl_i}),
        .level_out (pins_lvl)
    );

    assign scl_lvl = pins_lvl[0];
    assign sda_lvl = pins_lvl[1];

    its_cond_det u_cond (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .scl_lvl   (scl_lvl),
        .sda_lvl   (sda_lvl),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    // ==========================================================
    // state
    logic [DATA_W-1:0] cfg_q;
    logic [DATA_W-1:0] own_q;
    logic [DATA_W-1:0] buf_q;
    logic [DATA_W-1:0] rx_sh_q;
    logic [CNT_W-1:0]  cnt_q;
    its_state_e        state_q;
    logic              start_q;
    logic              stop_q;
    logic              dir_q;
    logic              data_q;
    logic              full_q;
    logic              nack_q;
    logic              wcol_q;
    logic              ovr_q;
    logic              ack_q;
    logic [IRQ_W-1:0]  irq_stat_q;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic              irq_q;
    logic [DATA_W-1:0] rdata_q;
    logic              scl_oe_q;
    logic              sda_oe_q;

    // ==========================================================
    // decode
    logic active;
    logic wr_own;
    logic wr_cfg;
    logic wr_stat;
    logic wr_buf;
    logic wr_irq_stat;
    logic wr_irq_mask;
    logic rd_buf;
    logic tx_busy;
    logic addr_match;
    logic addr_done;
    logic rx_done;
    logic rx_accept;
    logic rx_overrun;
    logic tx_done;
    logic buf_wr_ok;
    logic wcol_evt;
    logic tx_bit;

    // soft reset bit parks the sequencer like a cleared enable
    assign active      = cfg_q[CFG_EN] & ~cfg_q[CFG_SOFT_RST];
    assign wr_own      = reg_wr & (reg_addr == ADR_OWN);
    assign wr_cfg      = reg_wr & (reg_addr == ADR_CFG);
    assign wr_stat     = reg_wr & (reg_addr == ADR_STAT);
    assign wr_buf      = reg_wr & (reg_addr == ADR_BUF);
    assign wr_irq_stat = reg_wr & (reg_addr == ADR_IRQ_STAT);
    assign wr_irq_mask = reg_wr & (reg_addr == ADR_IRQ_MASK);
    assign rd_buf      = reg_rd & (reg_addr == ADR_BUF);

    assign addr_match = (rx_sh_q[DATA_W-1:1] == own_q[DATA_W-1:1]);
    assign addr_done  = (state_q == ST_ADDR) & scl_fall & (cnt_q == CNT_BYTE)
                        & addr_match;
    assign rx_done    = (state_q == ST_RX) & scl_fall & (cnt_q == CNT_BYTE);
    assign rx_accept  = rx_done & ~full_q;
    assign rx_overrun = rx_done & full_q;
    assign tx_done    = (state_q == ST_TX) & scl_fall & full_q
                        & (cnt_q == CNT_TXEND);
    assign tx_busy    = (state_q == ST_TX) & full_q;
    assign buf_wr_ok  = wr_buf & ~tx_busy;
    assign wcol_evt   = wr_buf & tx_busy;
    assign tx_bit     = buf_q[TX_MSB - cnt_q[2:0]];

    // ==========================================================
    // target sequencer
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !active) begin
            state_q <= ST_IDLE;
            cnt_q   <= CNT_ZERO;
        end else if (stop_det) begin
            state_q <= ST_IDLE;
            cnt_q   <= CNT_ZERO;
        end else if (start_det) begin
            state_q <= ST_ADDR;
            cnt_q   <= CNT_ZERO;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    cnt_q <= CNT_ZERO;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + CNT_ONE;
                    end else if (scl_fall && cnt_q == CNT_BYTE) begin
                        cnt_q   <= CNT_ZERO;
                        state_q <= addr_match ? ST_A_ACK : ST_IDLE;
                    end
                end
                ST_A_ACK: begin
                    if (scl_fall) begin
                        state_q <= dir_q ? ST_TX : ST_RX;
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + CNT_ONE;
                    end else if (rx_done) begin
                        cnt_q   <= CNT_ZERO;
                        state_q <= ST_RX_ACK;
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        state_q <= ST_RX;
                    end
                end
                ST_TX: begin
                    if (tx_done) begin
                        cnt_q   <= CNT_ZERO;
                        state_q <= ST_TX_ACK;
                    end else if (scl_fall) begin
                        cnt_q <= cnt_q + CNT_ONE;
                    end
                end
                ST_TX_ACK: begin
                    // a refused byte ends our part until the next start
                    if (scl_fall) begin
                        state_q <= nack_q ? ST_IDLE : ST_TX;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cnt_q   <= CNT_ZERO;
                end
            endcase
        end
    end

    // ==========================================================
    // receive shifter
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rx_sh_q <= ZERO_BYTE;
        end else if (scl_rise && (state_q == ST_ADDR || state_q == ST_RX)) begin
            rx_sh_q <= {rx_sh_q[DATA_W-2:0], sda_lvl};
        end
    end

    // ==========================================================
    // bus condition flags
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            start_q <= 1'b0;
            stop_q  <= 1'b1;
        end else if (start_det) begin
            start_q <= 1'b1;
            stop_q  <= 1'b0;
        end else if (stop_det) begin
            start_q <= 1'b0;
            stop_q  <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dir_q  <= 1'b0;
            data_q <= 1'b0;
        end else if (addr_done) begin
            dir_q  <= rx_sh_q[0];
            data_q <= 1'b0;
        end else if (rx_done || tx_done) begin
            data_q <= 1'b1;
        end
    end

    // ==========================================================
    // buffer full flag; receive fill and send drain
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            full_q <= 1'b0;
        end else if (rx_accept) begin
            full_q <= 1'b1;
        end else if (tx_done) begin
            full_q <= 1'b0;
        end else if (buf_wr_ok && dir_q) begin
            full_q <= 1'b1;
        end else if (rd_buf && !dir_q) begin
            full_q <= 1'b0;
        end
    end

    // ==========================================================
    // acknowledge tracking
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            nack_q <= 1'b1;
            ack_q  <= 1'b0;
        end else if (addr_done) begin
            nack_q <= 1'b0;
            ack_q  <= 1'b1;
        end else if (rx_done) begin
            nack_q <= rx_overrun;
            ack_q  <= rx_accept;
        end else if (state_q == ST_TX_ACK && scl_rise) begin
            nack_q <= sda_lvl;
        end
    end

    // ==========================================================
    // error flags: writing 0 clears, writing 1 is ignored, set wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wcol_q <= 1'b0;
            ovr_q  <= 1'b0;
        end else begin
            if (wcol_evt) begin
                wcol_q <= 1'b1;
            end else if (wr_stat && !reg_wdata[ST_WCOL]) begin
                wcol_q <= 1'b0;
            end
            if (rx_overrun) begin
                ovr_q <= 1'b1;
            end else if (wr_stat && !reg_wdata[ST_OVR]) begin
                ovr_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // data buffer; an overrun byte never reaches it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            buf_q <= BUF_RESET;
        end else if (rx_accept) begin
            buf_q <= rx_sh_q;
        end else if (buf_wr_ok) begin
            buf_q <= reg_wdata;
        end
    end

    // ==========================================================
    // configuration and own address
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg_q <= CFG_RESET;
            own_q <= OWN_RESET;
        end else begin
            if (wr_cfg) begin
                cfg_q <= reg_wdata & CFG_MASK;
            end
            if (wr_own) begin
                own_q <= reg_wdata;
            end
        end
    end

    // ==========================================================
    // pin drivers, open drain: enable high pulls the line low
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            // stretch only before a byte starts, never mid-byte
            scl_oe_q <= active & (~cfg_q[CFG_CLK_REL]
                        | (cfg_q[CFG_RD_STRTCH] & (state_q == ST_TX)
                           & ~full_q & (cnt_q == CNT_ZERO)));
            sda_oe_q <= active & ((state_q == ST_A_ACK)
                        | ((state_q == ST_RX_ACK) & ack_q)
                        | (tx_busy & ~tx_bit));
        end
    end

    assign scl_o  = 1'b0;
    assign sda_o  = 1'b0;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;

    // ==========================================================
    // interrupts: sticky, write 1 clears, a new event wins
    logic [IRQ_W-1:0] irq_evt;

    always_comb begin
        irq_evt            = IRQ_NONE;
        irq_evt[IRQ_START] = start_det & active;
        irq_evt[IRQ_STOP]  = stop_det & active;
        irq_evt[IRQ_RX]    = rx_accept | addr_done;
        irq_evt[IRQ_TX]    = tx_done;
        irq_evt[IRQ_ERR]   = wcol_evt | rx_overrun;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_stat_q <= IRQ_NONE;
            irq_mask_q <= IRQ_NONE;
            irq_q      <= 1'b0;
        end else begin
            if (wr_irq_stat) begin
                irq_stat_q <= (irq_stat_q & ~reg_wdata[IRQ_W-1:0]) | irq_evt;
            end else begin
                irq_stat_q <= irq_stat_q | irq_evt;
            end
            if (wr_irq_mask) begin
                irq_mask_q <= reg_wdata[IRQ_W-1:0];
            end
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign irq = irq_q;

    // ==========================================================
    // read port, data valid only in the cycle after the strobe
    logic [DATA_W-1:0] stat_word;
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        stat_word           = ZERO_BYTE;
        stat_word[ST_START] = start_q;
        stat_word[ST_STOP]  = stop_q;
        stat_word[ST_DIR]   = dir_q;
        stat_word[ST_DATA]  = data_q;
        stat_word[ST_FULL]  = full_q;
        stat_word[ST_NACK]  = nack_q;
        stat_word[ST_WCOL]  = wcol_q;
        stat_word[ST_OVR]   = ovr_q;
    end

    always_comb begin
        unique case (reg_addr)
            ADR_OWN:      rd_mux = own_q;
            ADR_CFG:      rd_mux = cfg_q;
            ADR_STAT:     rd_mux = stat_word;
            ADR_BUF:      rd_mux = buf_q;
            ADR_IRQ_STAT: rd_mux = {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q};
            ADR_IRQ_MASK: rd_mux = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};
            default:      rd_mux = ZERO_BYTE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_q <= ZERO_BYTE;
        end else begin
            rdata_q <= reg_rd ? rd_mux : ZERO_BYTE;
        end
    end

    assign reg_rdata = rdata_q;

endmodule : its_target

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import its_pkg::*;
    logic        ref_clk   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        rd_d      = 1'b0;
    logic [7:0]  reg_rdata;
    logic        scl_o, scl_oe, sda_o, sda_oe, irq, scl_drv, sda_drv;
    wire         scl_i = scl_drv & ~scl_oe;
    wire         sda_i = sda_drv & ~sda_oe;
    logic [15:0] exp_q[$];
    int          n_mismatch = 0;
    int          tests_run  = 0;
    always #5 ref_clk = ~ref_clk;
    its_target u_its_target (
        .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .irq
    );
    its_master_model u_mst (.scl_lvl(scl_i), .sda_lvl(sda_i), .scl_drv, .sda_drv);
    // ==========================================
    // tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    // expected value is queued with a mask of the bits that matter
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        exp_q.push_back({m, e & m});
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wt
    always @(posedge ref_clk) begin
        if (rd_d) begin
            logic [15:0] e;
            e = exp_q.pop_front();
            chk(reg_rdata & e[15:8], e[7:0]);
        end
        rd_d <= reg_rd;
    end
    initial begin
        #200us;
        n_mismatch++;
        report_and_stop();
    end
    // ==========================================
    // main sequence
    initial begin
        int unsigned r;
        logic [7:0]  d1, d2, got;
        logic        ack;
        void'($urandom(46471));
        r = $urandom();
        d1 = r[7:0];
        d2 = r[15:8];
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(ADR_STAT, 8'hff, 8'h44);
        rd(ADR_BUF, 8'hff, BUF_RESET);
        rd(8'h00, 8'hff, 8'h00);
        wr(ADR_STAT, 8'hff);
        rd(ADR_STAT, 8'hff, 8'h44);
        wr(ADR_OWN, 8'ha4);
        wr(ADR_IRQ_MASK, 8'h1f);
        u_mst.start_cond();
        u_mst.xfer(8'ha4, 1'b1, got, ack);
        u_mst.stop_cond();
        chk({7'h00, ack}, 8'h01);
        wr(ADR_CFG, 8'h15);
        wr(ADR_IRQ_STAT, 8'h1f);
        u_mst.start_cond();
        u_mst.xfer(8'ha4, 1'b1, got, ack);
        chk({7'h00, ack}, 8'h00);
        rd(ADR_STAT, 8'hfc, 8'h80);
        wr(ADR_IRQ_STAT, 8'h1f);
        u_mst.xfer(d1, 1'b1, got, ack);
        chk({7'h00, ack}, 8'h00);
        rd(ADR_STAT, 8'h1d, 8'h18);
        wt(2);
        chk({7'h00, irq}, 8'h01);
        u_mst.xfer(d2, 1'b1, got, ack);
        chk({7'h00, ack}, 8'h01);
        rd(ADR_STAT, 8'h0d, 8'h0d);
        rd(ADR_BUF, 8'hff, d1);
        rd(ADR_STAT, 8'h08, 8'h00);
        wr(ADR_STAT, 8'h00);
        rd(ADR_STAT, 8'h03, 8'h00);
        u_mst.stop_cond();
        rd(ADR_STAT, 8'hc0, 8'h40);
        wr(ADR_IRQ_MASK, 8'h00);
        wt(3);
        chk({7'h00, irq}, 8'h00);
        wr(ADR_IRQ_STAT, 8'h1f);
        wr(ADR_IRQ_MASK, 8'h1f);
        u_mst.start_cond();
        u_mst.xfer(8'ha5, 1'b1, got, ack);
        chk({7'h00, ack}, 8'h00);
        wt(20);
        chk({7'h00, scl_oe}, 8'h01);
        rd(ADR_STAT, 8'h20, 8'h20);
        fork
            u_mst.xfer(8'hff, 1'b1, got, ack);
            begin
                wr(ADR_BUF, d2);
                wt(30);
                wr(ADR_BUF, ~d2);
                rd(ADR_STAT, 8'h0a, 8'h0a);
            end
        join
        chk(got, d2);
        rd(ADR_STAT, 8'h0c, 8'h04);
        u_mst.stop_cond();
        wr(ADR_CFG, 8'h11);
        wt(3);
        chk({7'h00, scl_oe}, 8'h01);
        wr(ADR_CFG, 8'h15);
        wt(3);
        chk({7'h00, scl_oe}, 8'h00);
        wr(ADR_CFG, 8'h31);
        rd(ADR_CFG, 8'hff, 8'h31);
        wt(2);
        chk({7'h00, scl_oe}, 8'h00);
        report_and_stop();
    end
endmodule : tb_top
